// ### core/pmt_pkg.sv
package pmt_pkg;
    // register offsets in I/O space
    localparam logic [7:0] PMT_TIMER_OFS = 8'h08;
    localparam logic [7:0] PMT_THROTTLE_OFS = 8'h10;
    // field positions of the throttle control register
    localparam int PMT_FORCE_BIT = 8;
    localparam int PMT_DUTY_LSB = 5;
    localparam int PMT_DUTY_MSB = 7;
    localparam int PMT_STS_BIT = 17;
    // count width and rollover watch bit
    localparam int PMT_CNT_W = 24;
    localparam int PMT_ROLL_BIT = 22;
    // reference divider and throttle period
    localparam logic [1:0] PMT_REF_DIV_LAST = 2'h3;
    localparam int PMT_PERIOD_W = 10;
    localparam logic [2:0] PMT_DUTY_RESET = 3'h0;
    // thermal alarm hold time
    localparam int PMT_CLK_MHZ = 40;
    localparam int PMT_ALARM_HOLD_S = 2;
    localparam longint PMT_ALARM_HOLD_CYC = longint'(PMT_ALARM_HOLD_S) * PMT_CLK_MHZ * 1000000;
    localparam int PMT_ALARM_W = 27;

    // one I/O cycle towards the block
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [31:0] wdata;
    } pmt_io_req_t;

    // clocks of stop time per period for each duty code
    function automatic logic [PMT_PERIOD_W-1:0] pmt_duty_clocks(input logic [2:0] sel);
        case (sel)
            3'h1: pmt_duty_clocks = 10'h380;
            3'h2: pmt_duty_clocks = 10'h300;
            3'h3: pmt_duty_clocks = 10'h280;
            3'h4: pmt_duty_clocks = 10'h200;
            3'h5: pmt_duty_clocks = 10'h180;
            3'h6: pmt_duty_clocks = 10'h100;
            3'h7: pmt_duty_clocks = 10'h080;
            default: pmt_duty_clocks = 10'h200;
        endcase
    endfunction : pmt_duty_clocks
endpackage : pmt_pkg

// ### core/pmt_timer_throttle.sv
`timescale 1ns/1ps
module pmt_timer_throttle
    import pmt_pkg::*;
#(
    parameter longint ALARM_HOLD_CYC = PMT_ALARM_HOLD_CYC
) (
    input wire logic clk_sys_i, // 40 MHz system clock
    input wire logic rst_i, // async reset, active high
    input wire pmt_io_req_t io_req_i, // I/O cycle, wr/rd one-cycle strobes
    output logic [31:0] io_rdata_o, // read data, valid cycle after rd
    input wire logic ref_clk_pin_i, // 14.31818 MHz reference pin
    input wire logic pci_bus_reset_n_i, // PCI bus reset pin, active low
    input wire logic pci_tick_i, // one pulse per PCI clock, same domain
    input wire logic thermal_alarm_pin_n_i, // thermal alarm pin, active low
    input wire logic s0_state_i, // system in working state
    input wire logic c0_state_i, // processor in C0
    input wire logic rollover_irq_enable_i, // rollover interrupt enable
    input wire logic interrupt_route_select_i, // 0 management, 1 control irq
    input wire logic rollover_flag_clear_i, // clears rollover flag
    output logic count_rollover_flag_o, // sticky rollover flag
    output logic system_ctrl_interrupt_o, // control interrupt pulse
    output logic system_mgmt_interrupt_o, // management interrupt pulse
    output logic cpu_clock_stop_n_o // processor clock stop, active low
);
    logic [2:0] ref_sync_r, prst_sync_r, alarm_sync_r;
    logic prst_lvl_r, alarm_lvl_r;
    logic ref_rise;
    logic [1:0] ref_div_r;
    logic count_tick;
    logic [PMT_CNT_W-1:0] count_r, count_nxt;
    logic roll_evt;
    logic force_r;
    logic [2:0] duty_r;
    logic duty_locked_r;
    logic thr_wr;
    logic [PMT_ALARM_W-1:0] alarm_cnt_r;
    logic alarm_long_r;
    logic alarm_reached;
    logic throttling;
    logic [PMT_PERIOD_W-1:0] period_r;

    // three-stage synchronisers for pin inputs
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            ref_sync_r <= 3'h0;
            prst_sync_r <= 3'h0;
            alarm_sync_r <= 3'h7;
        end else begin
            ref_sync_r <= {ref_sync_r[1:0], ref_clk_pin_i};
            prst_sync_r <= {prst_sync_r[1:0], pci_bus_reset_n_i};
            alarm_sync_r <= {alarm_sync_r[1:0], thermal_alarm_pin_n_i};
        end
    end

    // filtered levels follow once stages two and three agree
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            prst_lvl_r <= 1'b0;
            alarm_lvl_r <= 1'b1;
        end else begin
            if (prst_sync_r[1] == prst_sync_r[2]) prst_lvl_r <= prst_sync_r[2];
            if (alarm_sync_r[1] == alarm_sync_r[2]) alarm_lvl_r <= alarm_sync_r[2];
        end
    end

    wire pci_rst_act = ~prst_lvl_r; // bus reset asserted
    // reference edge straight from stages two and three, since one phase
    // of the reference may span a single sample and a filter would drop it
    assign ref_rise = ref_sync_r[1] && !ref_sync_r[2];

    // divide reference by four
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) ref_div_r <= 2'h0;
        else if (ref_rise) ref_div_r <= ref_div_r + 2'h1;
    end
    assign count_tick = ref_rise && (ref_div_r == PMT_REF_DIV_LAST);

    // free-running count
    assign count_nxt = count_r + {{(PMT_CNT_W-1){1'b0}}, 1'b1};
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) count_r <= '0;
        else if (pci_rst_act) count_r <= '0;
        else if (count_tick && s0_state_i) count_r <= count_nxt;
    end

    // bit 22 falling edge event
    assign roll_evt = !pci_rst_act && count_tick && s0_state_i
                      && count_r[PMT_ROLL_BIT] && !count_nxt[PMT_ROLL_BIT];

    // sticky flag, a new event wins over a clear
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) count_rollover_flag_o <= 1'b0;
        else if (roll_evt) count_rollover_flag_o <= 1'b1;
        else if (rollover_flag_clear_i) count_rollover_flag_o <= 1'b0;
    end

    // thermal alarm hold counter
    assign alarm_reached = (alarm_cnt_r == PMT_ALARM_W'(ALARM_HOLD_CYC));
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            alarm_cnt_r <= '0;
            alarm_long_r <= 1'b0;
        end else if (alarm_lvl_r) begin
            alarm_cnt_r <= '0;
            alarm_long_r <= 1'b0;
        end else begin
            if (!alarm_reached) alarm_cnt_r <= alarm_cnt_r + PMT_ALARM_W'(1);
            alarm_long_r <= alarm_reached;
        end
    end

    // interrupt pulses
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            system_ctrl_interrupt_o <= 1'b0;
            system_mgmt_interrupt_o <= 1'b0;
        end else begin
            system_ctrl_interrupt_o <= roll_evt && rollover_irq_enable_i
                                       && interrupt_route_select_i;
            system_mgmt_interrupt_o <= (roll_evt && rollover_irq_enable_i
                                        && !interrupt_route_select_i)
                                       || (alarm_reached && !alarm_long_r && !force_r);
        end
    end

    // throttle control register writes
    assign thr_wr = io_req_i.wr && (io_req_i.addr == PMT_THROTTLE_OFS);
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            force_r <= 1'b0;
            duty_r <= PMT_DUTY_RESET;
            duty_locked_r <= 1'b0;
        end else if (pci_rst_act) begin
            force_r <= 1'b0;
            duty_r <= PMT_DUTY_RESET;
            duty_locked_r <= 1'b0;
        end else if (thr_wr) begin
            force_r <= io_req_i.wdata[PMT_FORCE_BIT];
            duty_locked_r <= 1'b1;
            if (!duty_locked_r) duty_r <= io_req_i.wdata[PMT_DUTY_MSB:PMT_DUTY_LSB];
        end
    end

    // override from force bit or held alarm, no disable
    assign throttling = (force_r || alarm_long_r) && c0_state_i;

    // throttle period counter
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) period_r <= '0;
        else if (!throttling) period_r <= '0;
        else if (pci_tick_i) period_r <= period_r + PMT_PERIOD_W'(1);
    end

    // stop output, low for the duty part of each period
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) cpu_clock_stop_n_o <= 1'b1;
        else cpu_clock_stop_n_o <= !(throttling && (period_r < pmt_duty_clocks(duty_r)));
    end

    // register read data
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) io_rdata_o <= 32'h0;
        else if (io_req_i.rd) begin
            io_rdata_o <= 32'h0;
            if (io_req_i.addr == PMT_TIMER_OFS) io_rdata_o[PMT_CNT_W-1:0] <= count_r;
            if (io_req_i.addr == PMT_THROTTLE_OFS) begin
                io_rdata_o[PMT_STS_BIT] <= throttling;
                io_rdata_o[PMT_FORCE_BIT] <= force_r;
                io_rdata_o[PMT_DUTY_MSB:PMT_DUTY_LSB] <= duty_r;
            end
        end
    end

    sequence s_bit22_fall;
        roll_evt;
    endsequence

    a_roll_flag_set: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        s_bit22_fall |=> count_rollover_flag_o) else $error("rollover flag not set");
    a_count_reset_zero: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        pci_rst_act |=> count_r == '0) else $error("count not cleared in bus reset");
    a_count_step_one: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (!pci_rst_act && count_tick && s0_state_i) |=> count_r == $past(count_r) + 24'h1)
        else $error("count did not step by one");
    a_count_hold_idle: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (!pci_rst_act && !count_tick) |=> $stable(count_r)) else $error("count moved off tick");
    a_ctrl_irq_route: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (s_bit22_fall and rollover_irq_enable_i && interrupt_route_select_i)
        |=> system_ctrl_interrupt_o && !system_mgmt_interrupt_o)
        else $error("control interrupt missing");
    a_mgmt_irq_route: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (s_bit22_fall and rollover_irq_enable_i && !interrupt_route_select_i)
        |=> system_mgmt_interrupt_o && !system_ctrl_interrupt_o)
        else $error("management interrupt missing");
    a_no_smi_forced: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (force_r && !roll_evt) |=> !system_mgmt_interrupt_o) else $error("irq while forced");
    a_duty_locked: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (duty_locked_r && !pci_rst_act) |=> $stable(duty_r)) else $error("locked duty changed");
    a_stop_outside_c0: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !c0_state_i |=> cpu_clock_stop_n_o) else $error("stop asserted outside C0");
    a_force_immediate: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (force_r && c0_state_i && period_r == '0) |=> !cpu_clock_stop_n_o)
        else $error("forced throttle not immediate");
    a_status_tracks: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (io_req_i.rd && io_req_i.addr == PMT_THROTTLE_OFS)
        |=> io_rdata_o[PMT_STS_BIT] == $past(throttling)) else $error("status bit wrong");
    a_timer_upper_zero: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (io_req_i.rd && io_req_i.addr == PMT_TIMER_OFS)
        |=> io_rdata_o[31:PMT_CNT_W] == '0) else $error("timer upper bits not zero");
endmodule : pmt_timer_throttle

// ### verification/pmt_cpu_model.sv
`timescale 1ns/1ps
// processor side: counts stopped cycles over one throttle window
module pmt_cpu_model #(
    parameter int WIN = 2048
) (
    input wire logic clk_sys_i, // system clock
    input wire logic cpu_clock_stop_n_i, // clock stop from block
    input wire logic start_i, // opens a new window
    output logic [11:0] low_count_o, // stopped cycles seen
    output logic done_o // window complete
);
    int n = 0;
    logic done_r = 1'b1;
    logic [11:0] low_r = 12'h0;
    assign done_o = done_r;
    assign low_count_o = low_r;
    // low level means the processor clock is stopped
    always @(posedge clk_sys_i) begin
        if (start_i) begin
            n <= 0;
            low_r <= 12'h0;
            done_r <= 1'b0;
        end else if (!done_r) begin
            n <= n + 1;
            if (cpu_clock_stop_n_i === 1'b0) low_r <= low_r + 12'h1;
            if (n == WIN - 1) done_r <= 1'b1;
        end
    end
endmodule : pmt_cpu_model

// ### verification/testbench.sv
`timescale 1ns/1ps
module testbench;
    import pmt_pkg::*;
    logic clk_sys_i = 0, rst_i = 1, ref_clk = 0, bus_rst_n = 0, tick = 0;
    logic alarm_n = 1, s0 = 1, c0 = 1, start = 0, flag, sci, smi, stop_n, done;
    pmt_io_req_t io_req = '0;
    logic [31:0] rdata, v0, v1;
    logic [11:0] low;
    int err_count = 0, cmp_count = 0, smi_count = 0, sci_count = 0;
    // stop clocks per period for each duty code
    logic [11:0] duty_tab [8] = '{12'h200, 12'h380, 12'h300, 12'h280,
                                  12'h200, 12'h180, 12'h100, 12'h080};
    always #12.5 clk_sys_i = ~clk_sys_i;
    always #34.92 ref_clk = ~ref_clk;
    // pci tick every other system cycle
    always @(negedge clk_sys_i) tick <= ~tick;
    // interrupt pulses counted mid-cycle where they are settled
    always @(negedge clk_sys_i) if (smi === 1'b1) smi_count++;
    always @(negedge clk_sys_i) if (sci === 1'b1) sci_count++;
    pmt_timer_throttle #(.ALARM_HOLD_CYC(50)) dut (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .io_req_i(io_req), .io_rdata_o(rdata),
        .ref_clk_pin_i(ref_clk), .pci_bus_reset_n_i(bus_rst_n), .pci_tick_i(tick),
        .thermal_alarm_pin_n_i(alarm_n), .s0_state_i(s0), .c0_state_i(c0),
        .rollover_irq_enable_i(1'b1), .interrupt_route_select_i(1'b0),
        .rollover_flag_clear_i(1'b0), .count_rollover_flag_o(flag),
        .system_ctrl_interrupt_o(sci), .system_mgmt_interrupt_o(smi),
        .cpu_clock_stop_n_o(stop_n));
    pmt_cpu_model #(.WIN(2048)) cpu (.clk_sys_i(clk_sys_i), .cpu_clock_stop_n_i(stop_n),
        .start_i(start), .low_count_o(low), .done_o(done));
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic io_wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge clk_sys_i);
        io_req = {a, 2'b10, d};
        @(negedge clk_sys_i);
        io_req = '0;
    endtask : io_wr
    task automatic io_rd(input logic [7:0] a, output logic [31:0] d);
        @(negedge clk_sys_i);
        io_req = {a, 2'b01, 32'h0};
        @(negedge clk_sys_i);
        io_req = '0;
        d = rdata;
    endtask : io_rd
    task automatic bus_reset();
        bus_rst_n = 0;
        repeat (10) @(negedge clk_sys_i);
        bus_rst_n = 1;
        repeat (10) @(negedge clk_sys_i);
    endtask : bus_reset
    // stopped cycles over one window, bounded wait
    task automatic measure(input logic [11:0] exp);
        int i;
        start = 1;
        @(negedge clk_sys_i);
        start = 0;
        for (i = 0; i < 5000 && done !== 1'b1; i++) @(negedge clk_sys_i);
        if (i == 5000) begin
            err_count++;
            $display("mismatch at %0t: throttle window timed out", $time);
            report_and_stop();
        end
        chk({20'h0, low}, {20'h0, exp});
    endtask : measure
    // main sequence
    initial begin
        repeat (5) @(negedge clk_sys_i);
        rst_i = 0;
        repeat (20) @(negedge clk_sys_i);
        io_rd(PMT_TIMER_OFS, v0);
        chk(v0, 32'h0);
        bus_rst_n = 1;
        repeat (1000) @(negedge clk_sys_i);
        io_rd(PMT_TIMER_OFS, v0);
        io_wr(PMT_TIMER_OFS, 32'h00ffffff);
        repeat (1000) @(negedge clk_sys_i);
        io_rd(PMT_TIMER_OFS, v1);
        chk({24'h0, v1[31:24]}, 32'h0);
        chk(((v1 - v0) inside {[88:91]}) ? 32'h1 : 32'h0, 32'h1);
        s0 = 0;
        io_rd(PMT_TIMER_OFS, v0);
        repeat (500) @(negedge clk_sys_i);
        io_rd(PMT_TIMER_OFS, v1);
        chk(v1, v0);
        s0 = 1;
        $display("test timer done");
        for (int k = 0; k < 8; k++) begin
            bus_reset();
            io_wr(PMT_THROTTLE_OFS, 32'h100 | (k << 5));
            io_wr(PMT_THROTTLE_OFS, 32'h100 | ((7 - k) << 5));
            io_rd(PMT_THROTTLE_OFS, v0);
            chk(v0, 32'h20100 | (k << 5));
            measure(duty_tab[k] << 1);
        end
        // alarm held past its hold time while forced: still no management irq
        alarm_n = 0;
        repeat (100) @(negedge clk_sys_i);
        alarm_n = 1;
        repeat (10) @(negedge clk_sys_i);
        chk(smi_count, 32'h0);
        $display("test forced duty done");
        c0 = 0;
        repeat (10) @(negedge clk_sys_i);
        io_rd(PMT_THROTTLE_OFS, v0);
        chk({31'h0, v0[17]}, 32'h0);
        measure(12'h0);
        c0 = 1;
        $display("test outside c0 done");
        bus_reset();
        alarm_n = 0;
        repeat (100) @(negedge clk_sys_i);
        chk(smi_count, 32'h1);
        measure(12'h400);
        alarm_n = 1;
        $display("test thermal alarm done");
        // count never reaches a bit 22 fall in this run
        chk({31'h0, flag}, 32'h0);
        chk(sci_count, 32'h0);
        report_and_stop();
    end
endmodule : testbench
